// File: logic/twm_params.svh
// Constants for the two-wire master transmitter: offsets, codes, timing.
`ifndef TWM_PARAMS_SVH
`define TWM_PARAMS_SVH
`define TWM_ADDR_W 8
`define TWM_OFF_CTRL 8'h00
`define TWM_OFF_STAT 8'h04
`define TWM_OFF_DATA 8'h08
`define TWM_CTRL_RST 8'h00
`define TWM_STAT_RST 8'hF8
`define TWM_DATA_RST 8'hFF
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_AW_ACK 8'h18
`define TWM_ST_AW_NACK 8'h20
`define TWM_ST_D_ACK 8'h28
`define TWM_ST_D_NACK 8'h30
`define TWM_ST_ARB 8'h38
`define TWM_ST_AR_ACK 8'h40
`define TWM_ST_AR_NACK 8'h48
`define TWM_ST_RX_ACK 8'h50
`define TWM_ST_RX_NACK 8'h58
`define TWM_BITS 4'h8
`define TWM_T_HALF_NS 5000
`define TWM_CLK_NS 40
`define TWM_CNT_W 16
`endif

// File: logic/twm_pkg.sv
// Types shared by the two-wire master transmitter.
package twm_pkg;
  typedef struct packed {
    logic flag;
    logic ack_en;
    logic start_request_field;
    logic stop_request_field;
    logic wc;
    logic en;
    logic rsvd;
    logic ie;
  } twm_ctrl_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } twm_line_t;

  typedef enum logic [3:0] {
    TWM_IDLE = 4'h0,
    TWM_FREE = 4'h1,
    TWM_START = 4'h3,
    TWM_HOLD = 4'h2,
    TWM_BIT_LO = 4'h6,
    TWM_BIT_HI = 4'h7,
    TWM_RS_LO = 4'h5,
    TWM_RS_HI = 4'h4,
    TWM_STOP_LO = 4'hC,
    TWM_STOP_HI = 4'hD
  } twm_state_t;
endpackage

// File: logic/twm_master.sv
// Two-wire bus master transmitter with an AHB-Lite register slave.
// Operation
// - Master mode only after START is sent.
// - Address read bit selects receive, else transmit.
// - Status code sits in upper five bits.
// - Start request; writing flag one clears it.
// - START generated only when bus is free.
// - After START, set flag, post 0x08.
// - Address sent: 0x18 on ack, 0x20 nack.
// - After address, post 0x18, 0x20 or 0x38.
// - Data write with flag low: ignored, collision.
// - Plain flag clear transmits loaded byte.
// - Data byte sent: 0x28 ack, 0x30 nack.
// - Hold at completion until flag cleared.
// - Stop request sends STOP, self-clears stop bit.
// - Start request sends repeated START.
// - Both requests: STOP, START, clear stop bit.
// - Repeated START posts 0x10, readdressing allowed.
// - Read address at 0x10 switches to receive.
// - Arbitration loss sets flag, posts 0x38.
// - At 0x38, release or restart when free.
`timescale 1ns/10ps
`include "twm_params.svh"
module twm_master #(
  parameter int HALF_CYC = (`TWM_T_HALF_NS + `TWM_CLK_NS - 1) / `TWM_CLK_NS
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  localparam logic [`TWM_CNT_W-1:0] HALF_LD = `TWM_CNT_W'(HALF_CYC - 1);

  generate
    if (HALF_CYC < 2 || HALF_CYC > (1 << `TWM_CNT_W))
    begin : g_bad_half
      $error("HALF_CYC out of range");
    end
  endgenerate

  function automatic logic reg_hit(input logic [`TWM_ADDR_W-1:0] a,
                                   input logic [`TWM_ADDR_W-1:0] off);
    reg_hit = (a == off);
  endfunction

  twm_pkg::twm_ctrl_t ctrl;
  twm_pkg::twm_ctrl_t wctl;
  twm_pkg::twm_state_t state;
  twm_pkg::twm_line_t drive;
  logic [7:0] status;
  logic [7:0] data_byte;
  logic [7:0] shifter;
  logic [3:0] bit_cnt;
  logic [`TWM_CNT_W-1:0] cnt;
  logic tick;
  logic master_mode;
  logic read_mode;
  logic addr_phase;
  logic is_rs;
  logic restart_after;
  logic busy;
  logic set_ev;
  logic [7:0] ev_code;
  logic sto_clr;
  logic rx_done;
  logic receiving;
  logic scl_m;
  logic scl_s;
  logic sda_m;
  logic sda_s;
  logic sda_d;
  logic ap_valid;
  logic ap_write;
  logic [`TWM_ADDR_W-1:0] ap_addr;
  logic wr_ctrl;
  logic wr_data;
  logic idle_go;
  logic hold_go;
  logic en_live;

  // Bus lines are asynchronous to the core clock; only scl_s, sda_s and
  // its delayed copy sda_d are looked at by the logic below.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end
    else if (ce_i)
    begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // Bus busy tracking from START and STOP seen on the lines.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      busy <= 1'b0;
    end
    else if (ce_i)
    begin
      if (sda_d && !sda_s && scl_s)
      begin
        busy <= 1'b1;
      end
      else if (!sda_d && sda_s && scl_s)
      begin
        busy <= 1'b0;
      end
    end
  end

  // AHB-Lite address phase capture; the slave never inserts wait states
  // except while the clock enable freezes it.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= '0;
      hrdata_o <= '0;
    end
    else if (ce_i)
    begin
      ap_valid <= hsel_i && htrans_i[1] && hready_i;
      ap_write <= hwrite_i;
      ap_addr <= haddr_i[`TWM_ADDR_W-1:0];
      if (hsel_i && htrans_i[1] && hready_i && !hwrite_i)
      begin
        if (reg_hit(haddr_i[`TWM_ADDR_W-1:0], `TWM_OFF_CTRL))
        begin
          hrdata_o <= {24'h000000, ctrl};
        end
        else if (reg_hit(haddr_i[`TWM_ADDR_W-1:0], `TWM_OFF_STAT))
        begin
          hrdata_o <= {24'h000000, status};
        end
        else if (reg_hit(haddr_i[`TWM_ADDR_W-1:0], `TWM_OFF_DATA))
        begin
          hrdata_o <= {24'h000000, data_byte};
        end
        else
        begin
          hrdata_o <= '0;
        end
      end
    end
  end

  assign hreadyout_o = ce_i;
  assign hresp_o = 1'b0;
  assign wctl = hwdata_i[7:0];
  assign wr_ctrl = ce_i && ap_valid && ap_write &&
                   reg_hit(ap_addr, `TWM_OFF_CTRL);
  assign wr_data = ce_i && ap_valid && ap_write &&
                   reg_hit(ap_addr, `TWM_OFF_DATA);
  // A start request from idle needs the enable and start bits together.
  assign idle_go = wr_ctrl && wctl.en && wctl.start_request_field &&
                   (wctl.flag || !ctrl.flag) &&
                   (state == twm_pkg::TWM_IDLE);
  // Only a one written to a set flag releases a held step.
  assign hold_go = wr_ctrl && wctl.flag && wctl.en && ctrl.flag &&
                   (state == twm_pkg::TWM_HOLD) && master_mode;
  assign receiving = read_mode && !addr_phase;
  assign tick = (cnt == '0);
  // An enable written together with a start request acts in that same
  // cycle; waiting for the stored bit would swallow the first request.
  assign en_live = wr_ctrl ? wctl.en : ctrl.en;

  // Control register; hardware set of the flag wins over a software clear.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= `TWM_CTRL_RST;
    end
    else if (ce_i)
    begin
      if (set_ev)
      begin
        ctrl.flag <= 1'b1;
      end
      else if (wr_ctrl && wctl.flag)
      begin
        ctrl.flag <= 1'b0;
      end
      if (wr_ctrl)
      begin
        ctrl.ack_en <= wctl.ack_en;
        ctrl.start_request_field <= wctl.start_request_field;
        ctrl.stop_request_field <= wctl.stop_request_field;
        ctrl.en <= wctl.en;
        ctrl.ie <= wctl.ie;
      end
      if (sto_clr)
      begin
        ctrl.stop_request_field <= 1'b0;
      end
      if (wr_data)
      begin
        ctrl.wc <= !ctrl.flag;
      end
      ctrl.rsvd <= 1'b0;
    end
  end

  // Status register holds the last posted step code.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      status <= `TWM_STAT_RST;
    end
    else if (ce_i && set_ev)
    begin
      status <= ev_code;
    end
  end

  // Data register; writes while a step runs would corrupt the shifter.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      data_byte <= `TWM_DATA_RST;
    end
    else if (ce_i)
    begin
      if (rx_done)
      begin
        data_byte <= shifter;
      end
      else if (wr_data && ctrl.flag)
      begin
        data_byte <= hwdata_i[7:0];
      end
    end
  end

  // Bus sequencer. Each bit is a low half then a high half; a slave
  // that stretches the clock restarts the high half count.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state <= twm_pkg::TWM_IDLE;
      drive <= '0;
      cnt <= '0;
      bit_cnt <= '0;
      shifter <= '0;
      master_mode <= 1'b0;
      read_mode <= 1'b0;
      addr_phase <= 1'b0;
      is_rs <= 1'b0;
      restart_after <= 1'b0;
      set_ev <= 1'b0;
      ev_code <= `TWM_STAT_RST;
      sto_clr <= 1'b0;
      rx_done <= 1'b0;
    end
    else if (ce_i)
    begin
      set_ev <= 1'b0;
      sto_clr <= 1'b0;
      rx_done <= 1'b0;
      if (!tick)
      begin
        cnt <= cnt - 1'b1;
      end
      if (!en_live)
      begin
        state <= twm_pkg::TWM_IDLE;
        drive <= '0;
        master_mode <= 1'b0;
      end
      else
      begin
        unique case (state)
          twm_pkg::TWM_IDLE:
          begin
            drive <= '0;
            master_mode <= 1'b0;
            if (idle_go)
            begin
              state <= twm_pkg::TWM_FREE;
            end
          end
          twm_pkg::TWM_FREE:
          begin
            is_rs <= 1'b0;
            if (!busy && tick)
            begin
              drive.sda <= 1'b1;
              cnt <= HALF_LD;
              state <= twm_pkg::TWM_START;
            end
          end
          twm_pkg::TWM_START:
          begin
            if (tick)
            begin
              drive.scl <= 1'b1;
              master_mode <= 1'b1;
              addr_phase <= 1'b1;
              set_ev <= 1'b1;
              ev_code <= is_rs ? `TWM_ST_RSTART : `TWM_ST_START;
              state <= twm_pkg::TWM_HOLD;
            end
          end
          twm_pkg::TWM_HOLD:
          begin
            if (hold_go)
            begin
              cnt <= HALF_LD;
              if (wctl.stop_request_field)
              begin
                drive.sda <= 1'b1;
                restart_after <= wctl.start_request_field;
                state <= twm_pkg::TWM_STOP_LO;
              end
              else if (wctl.start_request_field)
              begin
                drive.sda <= 1'b0;
                state <= twm_pkg::TWM_RS_LO;
              end
              else
              begin
                shifter <= data_byte;
                bit_cnt <= '0;
                if (addr_phase)
                begin
                  read_mode <= data_byte[0];
                  drive.sda <= !data_byte[7];
                end
                else
                begin
                  drive.sda <= !read_mode && !data_byte[7];
                end
                state <= twm_pkg::TWM_BIT_LO;
              end
            end
          end
          twm_pkg::TWM_BIT_LO:
          begin
            if (tick)
            begin
              drive.scl <= 1'b0;
              cnt <= HALF_LD;
              state <= twm_pkg::TWM_BIT_HI;
            end
          end
          twm_pkg::TWM_BIT_HI:
          begin
            if (!scl_s)
            begin
              cnt <= HALF_LD;
            end
            else if (tick && bit_cnt != `TWM_BITS)
            begin
              if (!receiving && !drive.sda && !sda_s)
              begin
                drive <= '0;
                master_mode <= 1'b0;
                set_ev <= 1'b1;
                ev_code <= `TWM_ST_ARB;
                state <= twm_pkg::TWM_IDLE;
              end
              else
              begin
                shifter <= {shifter[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
                drive.scl <= 1'b1;
                if (bit_cnt + 4'h1 == `TWM_BITS)
                begin
                  drive.sda <= receiving && ctrl.ack_en;
                end
                else
                begin
                  drive.sda <= !receiving && !shifter[6];
                end
                cnt <= HALF_LD;
                state <= twm_pkg::TWM_BIT_LO;
              end
            end
            else if (tick)
            begin
              drive.scl <= 1'b1;
              set_ev <= 1'b1;
              addr_phase <= 1'b0;
              state <= twm_pkg::TWM_HOLD;
              if (addr_phase && read_mode)
              begin
                ev_code <= sda_s ? `TWM_ST_AR_NACK : `TWM_ST_AR_ACK;
              end
              else if (addr_phase)
              begin
                ev_code <= sda_s ? `TWM_ST_AW_NACK : `TWM_ST_AW_ACK;
              end
              else if (read_mode)
              begin
                rx_done <= 1'b1;
                ev_code <= ctrl.ack_en ? `TWM_ST_RX_ACK : `TWM_ST_RX_NACK;
              end
              else
              begin
                ev_code <= sda_s ? `TWM_ST_D_NACK : `TWM_ST_D_ACK;
              end
            end
          end
          twm_pkg::TWM_RS_LO:
          begin
            if (tick)
            begin
              drive.scl <= 1'b0;
              cnt <= HALF_LD;
              state <= twm_pkg::TWM_RS_HI;
            end
          end
          twm_pkg::TWM_RS_HI:
          begin
            if (!scl_s)
            begin
              cnt <= HALF_LD;
            end
            else if (tick)
            begin
              drive.sda <= 1'b1;
              is_rs <= 1'b1;
              cnt <= HALF_LD;
              state <= twm_pkg::TWM_START;
            end
          end
          twm_pkg::TWM_STOP_LO:
          begin
            if (tick)
            begin
              drive.scl <= 1'b0;
              cnt <= HALF_LD;
              state <= twm_pkg::TWM_STOP_HI;
            end
          end
          twm_pkg::TWM_STOP_HI:
          begin
            if (!scl_s)
            begin
              cnt <= HALF_LD;
            end
            else if (tick)
            begin
              drive.sda <= 1'b0;
              sto_clr <= 1'b1;
              master_mode <= 1'b0;
              cnt <= HALF_LD;
              state <= restart_after ? twm_pkg::TWM_FREE :
                                       twm_pkg::TWM_IDLE;
            end
          end
          default:
          begin
            state <= twm_pkg::TWM_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain lines: the pad only ever pulls low.
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = drive.scl;
  assign sda_oe_o = drive.sda;
endmodule

// File: testbench/twm_master_assertions.sv
// Port assertions for the two-wire master transmitter.
`timescale 1ns/10ps
`include "twm_params.svh"
module twm_master_chk #(
  parameter int HALF_CYC = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic scl_i,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o
);
  localparam int START_MAX = HALF_CYC + 4;
  logic rd_req;
  int lo_cnt;
  assign rd_req = hsel_i & htrans_i[1] & hready_i & ce_i & ~hwrite_i;
  // Length of the current low clock phase, so short phases are caught.
  always_ff @(posedge core_clk_i)
  begin
    lo_cnt <= (rst_i || !scl_oe_o) ? 0 : lo_cnt + 1;
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  chk_idle_after_rst: assert property (
    $past(rst_i) |-> !scl_oe_o && !sda_oe_o)
    else $error("Lines driven right after reset.");
  chk_start_bus_free: assert property (
    $rose(sda_oe_o) && !scl_oe_o |-> scl_i)
    else $error("Start begun while the clock line was low.");
  chk_start_then_clk: assert property (
    $rose(sda_oe_o) && !scl_oe_o |-> ##[1:START_MAX] scl_oe_o)
    else $error("Clock line not taken after start.");
  chk_stop_order: assert property (
    $fell(sda_oe_o) && !scl_oe_o |-> !$past(scl_oe_o))
    else $error("Data line released together with the clock line.");
  chk_low_phase_len: assert property (
    $fell(scl_oe_o) |-> lo_cnt >= HALF_CYC)
    else $error("Clock low phase shorter than half a bit.");
  chk_status_low_zero: assert property (
    rd_req && haddr_i[7:0] == `TWM_OFF_STAT |=> hrdata_o[2:0] == 3'h0)
    else $error("Status low bits not zero.");
  chk_ctrl_rsvd_zero: assert property (
    rd_req && haddr_i[7:0] == `TWM_OFF_CTRL |=> !hrdata_o[1])
    else $error("Reserved control bit reads one.");
  chk_rdata_upper_zero: assert property (
    rd_req |=> hrdata_o[31:8] == 24'h0)
    else $error("Read data wider than a byte.");
endmodule
bind twm_master twm_master_chk #(.HALF_CYC(HALF_CYC)) u_chk (.core_clk_i,
  .rst_i, .ce_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i,
  .hrdata_o, .scl_i, .scl_oe_o, .sda_oe_o);

// File: testbench/twm_slave_model.sv
// Behavioural slave receiver on the two-wire bus.
`timescale 1ns/10ps
module twm_slave_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic nack_i,
  output logic sda_oe_o
);
  int cnt = 0;
  initial sda_oe_o = 1'b0;
  // A falling data line with the clock high is a start; framing restarts.
  // The clock is looked at a moment later, so a data change made in the
  // same instant as a falling clock edge is not taken for a start.
  always @(negedge sda_i)
  begin
    #1;
    if (scl_i === 1'b1 && sda_i === 1'b0)
    begin
      cnt <= 0;
    end
  end
  always @(posedge scl_i)
  begin
    cnt <= cnt + 1;
  end
  // The answer is held over the whole ninth clock, then dropped so the
  // pull-up restores the line.
  always @(negedge scl_i)
  begin
    sda_oe_o <= (cnt == 8) && !nack_i;
    if (cnt == 9)
    begin
      cnt <= 0;
    end
  end
endmodule

// File: testbench/test_two_wire_master_transmitter.sv
// Self-checking testbench for the two-wire master transmitter.
`timescale 1ns/10ps
`include "twm_params.svh"
module test_two_wire_master_transmitter;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic nack = 1'b0;
  logic rival = 1'b0;
  logic hready;
  logic [31:0] hrdata;
  logic m_scl_oe;
  logic m_sda_oe;
  logic s_sda_oe;
  logic [8:0] shift = 9'h0;
  logic [31:0] rd;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  wire scl = ~m_scl_oe;
  // Rival stands for a second master that wins arbitration.
  wire sda = ~(m_sda_oe | s_sda_oe | rival);
  always #20 clk = ~clk;
  twm_master #(.HALF_CYC(4)) u_dut (.core_clk_i(clk), .rst_i(rst),
    .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(), .hrdata_o(hrdata),
    .scl_i(scl), .scl_o(), .scl_oe_o(m_scl_oe), .sda_i(sda), .sda_o(),
    .sda_oe_o(m_sda_oe));
  twm_slave_model u_slave (.scl_i(scl), .sda_i(sda), .nack_i(nack),
    .sda_oe_o(s_sda_oe));
  // Last nine bits seen on the wire, byte plus answer bit.
  always @(posedge scl) shift <= {shift[7:0], sda};
  task automatic final_report;
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report;
    end
  end
  task automatic chk(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // An idle cycle first, so a write lands before the next address phase.
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [7:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic poll_flag;
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[7] !== 1'b1 && n < 200)
    begin
      ahb(1'b0, `TWM_OFF_CTRL, 8'h00);
      n++;
    end
    ahb(1'b0, `TWM_OFF_STAT, 8'h00);
  endtask
  task automatic step(input logic [7:0] code);
    poll_flag;
    chk("status", rd, {24'h0, code});
    repeat (16) @(posedge clk);
    chk("clock held", {31'h0, m_scl_oe}, 32'h1);
  endtask
  task automatic send(input logic [7:0] b, input logic [7:0] code);
    ahb(1'b1, `TWM_OFF_DATA, b);
    ahb(1'b1, `TWM_OFF_CTRL, 8'h84);
    step(code);
    chk("wire bits", {23'h0, shift}, {23'h0, b, nack});
  endtask
  task automatic t_regs;
    ahb(1'b0, `TWM_OFF_CTRL, 8'h00);
    chk("ctrl reset", rd, 32'h0);
    ahb(1'b0, `TWM_OFF_STAT, 8'h00);
    chk("status reset", rd, 32'hF8);
    ahb(1'b1, `TWM_OFF_DATA, 8'h3C);
    ahb(1'b0, `TWM_OFF_DATA, 8'h00);
    chk("data kept", rd, 32'hFF);
    ahb(1'b0, `TWM_OFF_CTRL, 8'h00);
    chk("collision", rd, 32'h08);
    ahb(1'b1, 8'h0C, 8'h55);
    ahb(1'b0, 8'h0C, 8'h00);
    chk("unmapped", rd, 32'h0);
  endtask
  task automatic t_xfer;
    ahb(1'b1, `TWM_OFF_CTRL, 8'hA4);
    step(`TWM_ST_START);
    send(8'hA0, `TWM_ST_AW_ACK);
    ahb(1'b0, `TWM_OFF_CTRL, 8'h00);
    chk("collision cleared", rd & 32'h08, 32'h0);
    send(8'h5A, `TWM_ST_D_ACK);
  endtask
  task automatic t_restart;
    ahb(1'b1, `TWM_OFF_CTRL, 8'hA4);
    step(`TWM_ST_RSTART);
    nack <= 1'b1;
    send(8'hB0, `TWM_ST_AW_NACK);
    send(8'h33, `TWM_ST_D_NACK);
  endtask
  task automatic t_combo;
    int n;
    ahb(1'b1, `TWM_OFF_CTRL, 8'hB4);
    step(`TWM_ST_START);
    ahb(1'b0, `TWM_OFF_CTRL, 8'h00);
    chk("stop bit cleared", rd & 32'h10, 32'h0);
    nack <= 1'b0;
    ahb(1'b1, `TWM_OFF_CTRL, 8'hA4);
    step(`TWM_ST_RSTART);
    send(8'hA1, `TWM_ST_AR_ACK);
    ahb(1'b1, `TWM_OFF_CTRL, 8'h94);
    n = 0;
    rd = 32'h10;
    while (rd[4] !== 1'b0 && n < 100)
    begin
      ahb(1'b0, `TWM_OFF_CTRL, 8'h00);
      n++;
    end
    chk("stop done", rd & 32'h90, 32'h0);
    repeat (8) @(posedge clk);
    chk("bus released", {30'h0, scl, sda}, 32'h3);
  endtask
  task automatic t_arb;
    ahb(1'b1, `TWM_OFF_CTRL, 8'hA4);
    step(`TWM_ST_START);
    ahb(1'b1, `TWM_OFF_DATA, 8'hFF);
    ahb(1'b1, `TWM_OFF_CTRL, 8'h84);
    rival <= 1'b1;
    poll_flag;
    chk("arbitration", rd, {24'h0, `TWM_ST_ARB});
    chk("arb release", {30'h0, m_scl_oe, m_sda_oe}, 32'h0);
    rival <= 1'b0;
    ahb(1'b1, `TWM_OFF_CTRL, 8'hA4);
    step(`TWM_ST_START);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_xfer;
    t_restart;
    t_combo;
    t_arb;
    final_report;
  end
endmodule
